// ### gpi_core.sv
// Purpose: General-purpose input roles for a multi-rail power sequencer
// Assumes: Pin mapping to inputs done upstream; config static in operation
// Notes:   Overview of operation follows
// Overview of operation
// - At most 32 of 84 pins are inputs
// - Per-input polarity selects asserted level
// - Any input usable as sequencing dependency
// - First three defined inputs select rail states
// - Fault-role input de-assertion is a fault
// - Clear-role input clears latched statuses
// - Margin enable puts enabled rails margined
// - Low select picks low, else high
// - Margin roles each on one input only
// - Debug blocks alert, response and logging
// - Debug ignores dependencies, sequences at timeout
// - Debug with zero timeout sequences immediately
// - Debug never pulls the fault bus low
// - Debug returns affected logic outputs
// - Debug leaves communication faults reported
// - Fault-bus role needs fault enable too
// - Idle fault-bus pin monitors bus level
// - Rail fault drives fault-bus pin low
// - Cleared fault releases fault-bus pin
// - Dependency met on assert on, de-assert off
// - Debug input events keep their function
module gpi_core #(
    parameter int NUM_IN = gpi_pkg::MAX_INPUTS,
    parameter int RAILS  = gpi_pkg::NUM_RAILS
) (
    // Clock and control
    input  wire logic                       clk_sys_in,
    input  wire logic                       sys_rst_in,
    input  wire logic                       clk_en_in,
    // Input pins and configuration
    input  wire logic [NUM_IN-1:0]          pin_level_in,
    input  wire logic [NUM_IN-1:0]          active_low_in,
    input  wire logic [NUM_IN-1:0]          defined_in,
    input  wire gpi_pkg::role_t [NUM_IN-1:0] role_in,
    // Sequencing
    input  wire logic [RAILS-1:0][NUM_IN-1:0] on_dep_in,
    input  wire logic [RAILS-1:0][NUM_IN-1:0] off_dep_in,
    input  wire gpi_pkg::seq_req_t          seq_req_in,
    input  wire logic [RAILS-1:0]           tmo_expired_in,
    input  wire logic [RAILS-1:0]           tmo_zero_in,
    input  wire logic [RAILS-1:0]           rail_dep_ok_in,
    input  wire logic [RAILS-1:0]           margin_allow_in,
    // Fault sources
    input  wire logic                       rail_fault_in,
    input  wire logic                       fault_clear_in,
    input  wire logic                       comm_fault_in,
    input  wire logic [15:0]                logic_out_fault_in,
    // Fault-bus pin
    input  wire logic                       fault_bus_pin_in,
    output logic                            fault_bus_pin_out,
    output logic                            fault_bus_pin_oe_out,
    // Results
    output logic [NUM_IN-1:0]               asserted_out,
    output logic [RAILS-1:0]                rail_on_go_out,
    output logic [RAILS-1:0]                rail_off_go_out,
    output logic [gpi_pkg::SEL_INPUTS-1:0]  state_sel_out,
    output logic                            input_fault_out,
    output logic                            shutdown_req_out,
    output logic                            fault_log_out,
    output logic                            bus_alert_pin_out,
    output logic                            latch_clear_out,
    output logic [RAILS-1:0]                margin_low_out,
    output logic [RAILS-1:0]                margin_high_out,
    output logic                            debug_mode_out,
    output logic                            comm_fault_status_register_out,
    output logic [15:0]                     logic_output_pin_out,
    output logic                            bus_fault_seen_out,
    output logic                            role_error_out
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (NUM_IN < 1 || NUM_IN > gpi_pkg::MAX_INPUTS) begin : g_chk
        $error("Input count must be 1 to 32");
    end
    if (RAILS < 1 || RAILS > gpi_pkg::NUM_RAILS) begin : g_chk_rails
        $error("Rail count must be 1 to 32");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [5:0] pop(input logic [NUM_IN-1:0] v);
        logic [5:0] c;
        c = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            c = c + 6'(v[i]);
        end
        return c;
    endfunction

    function automatic logic any_of(input logic [NUM_IN-1:0] sel,
                                    input logic [NUM_IN-1:0] lvl);
        return |(sel & lvl);
    endfunction

    // ************************************************************
    // Synchronise and apply polarity
    // ************************************************************
    logic [NUM_IN-1:0] asrt;
    logic              bus_sync_q1;
    logic              bus_sync_q2;

    gpi_sync #(.WIDTH(NUM_IN)) u_sync (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .clk_en_in     (clk_en_in),
        .raw_in        (pin_level_in),
        .active_low_in (active_low_in),
        .asserted_out  (asrt)
    );

    // ************************************************************
    // Role decode
    // ************************************************************
    logic [NUM_IN-1:0] r_fault;
    logic [NUM_IN-1:0] r_clr;
    logic [NUM_IN-1:0] r_men;
    logic [NUM_IN-1:0] r_mlo;
    logic [NUM_IN-1:0] r_dbg;
    logic [NUM_IN-1:0] r_bus;
    logic [NUM_IN-1:0] act;

    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            r_fault[i] = defined_in[i] & role_in[i].fault_en;
            r_clr[i]   = defined_in[i] & role_in[i].clr_latch;
            r_men[i]   = defined_in[i] & role_in[i].margin_en;
            r_mlo[i]   = defined_in[i] & role_in[i].margin_low;
            r_dbg[i]   = defined_in[i] & role_in[i].debug;
            // Bus role without fault enable stays dormant
            r_bus[i]   = r_fault[i] & role_in[i].fault_bus;
        end
        act = asrt & defined_in;
    end

    // First three defined inputs, in index order
    logic [gpi_pkg::SEL_INPUTS-1:0] sel_d;
    always_comb begin
        int n;
        n = 0;
        sel_d = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (defined_in[i] && n < gpi_pkg::SEL_INPUTS) begin
                sel_d[n] = act[i];
                n = n + 1;
            end
        end
    end

    // ************************************************************
    // Debug and margin
    // ************************************************************
    logic dbg;
    logic men;
    logic mlo;
    assign dbg = any_of(r_dbg, act);
    // Only a single input may carry each margin role
    assign men = any_of(r_men, act) && pop(r_men) == 6'h01;
    assign mlo = any_of(r_mlo, act) && pop(r_mlo) == 6'h01;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            debug_mode_out  <= 1'b0;
            role_error_out  <= 1'b0;
            margin_low_out  <= '0;
            margin_high_out <= '0;
            state_sel_out   <= '0;
            asserted_out    <= '0;
        end else if (clk_en_in) begin
            debug_mode_out  <= dbg;
            role_error_out  <= pop(r_men) > 6'h01 || pop(r_mlo) > 6'h01;
            // Margin direction follows the select only while enabled
            margin_low_out  <= (men && mlo) ? margin_allow_in : '0;
            margin_high_out <= (men && !mlo) ? margin_allow_in : '0;
            state_sel_out   <= sel_d;
            asserted_out    <= act;
        end
    end

    // ************************************************************
    // Sequencing dependencies
    // ************************************************************
    logic [RAILS-1:0] on_ok;
    logic [RAILS-1:0] off_ok;
    always_comb begin
        for (int r = 0; r < RAILS; r++) begin
            // On needs asserted, off needs de-asserted
            on_ok[r]  = ((on_dep_in[r] & ~act) == '0) && rail_dep_ok_in[r];
            off_ok[r] = ((off_dep_in[r] & act) == '0) && rail_dep_ok_in[r];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rail_on_go_out  <= '0;
            rail_off_go_out <= '0;
        end else if (clk_en_in) begin
            // Debug skips dependencies and waits for the timeout
            // A zero timeout releases at once
            rail_on_go_out  <= seq_req_in.on_seek[RAILS-1:0] &
                (dbg ? (tmo_expired_in | tmo_zero_in) : on_ok);
            rail_off_go_out <= seq_req_in.off_seek[RAILS-1:0] &
                (dbg ? (tmo_expired_in | tmo_zero_in) : off_ok);
        end
    end

    // ************************************************************
    // Faults, clear, alert
    // ************************************************************
    logic in_fault;
    logic any_fault;
    assign in_fault  = |(r_fault & ~asrt);
    assign any_fault = in_fault | rail_fault_in;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            input_fault_out   <= 1'b0;
            shutdown_req_out  <= 1'b0;
            fault_log_out     <= 1'b0;
            bus_alert_pin_out <= 1'b0;
            latch_clear_out   <= 1'b0;
            comm_fault_status_register_out <= 1'b0;
            logic_output_pin_out <= '0;
        end else if (clk_en_in) begin
            // Event still seen, response and logging withheld
            input_fault_out   <= in_fault;
            shutdown_req_out  <= any_fault && !dbg;
            fault_log_out     <= any_fault && !dbg;
            bus_alert_pin_out <= any_fault && !dbg;
            latch_clear_out   <= any_of(r_clr, act);
            // Set beats clear; debug never hides these
            comm_fault_status_register_out <= comm_fault_in ||
                (comm_fault_status_register_out && !latch_clear_out);
            // Suppressed events let the outputs fall back
            logic_output_pin_out <= dbg ? '0 : logic_out_fault_in;
        end
    end

    // ************************************************************
    // Fault bus
    // ************************************************************
    logic                           bus_drive_q;
    logic [gpi_pkg::ECHO_DEPTH-1:0] echo_q;
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            bus_drive_q <= 1'b0;
        end else if (clk_en_in) begin
            // Drive on fault, release on clear, and never in debug
            if (dbg || !(|r_bus)) begin
                bus_drive_q <= 1'b0;
            end else if (rail_fault_in) begin
                bus_drive_q <= 1'b1;
            end else if (fault_clear_in) begin
                bus_drive_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            bus_sync_q1          <= 1'b1;
            bus_sync_q2          <= 1'b1;
            echo_q               <= '0;
            bus_fault_seen_out   <= 1'b0;
            fault_bus_pin_out    <= 1'b0;
            fault_bus_pin_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            bus_sync_q1          <= fault_bus_pin_in;
            bus_sync_q2          <= bus_sync_q1;
            echo_q <= {echo_q[gpi_pkg::ECHO_DEPTH-2:0], bus_drive_q};
            // Low bus while we do not drive means a peer fault
            // Our own release needs the sync depth to show, so blank it
            bus_fault_seen_out   <= (|r_bus) && !bus_sync_q2 &&
                !bus_drive_q && !(|echo_q);
            fault_bus_pin_out    <= 1'b0;
            // Debug or a dropped role cut the pull at once
            fault_bus_pin_oe_out <= bus_drive_q && (|r_bus) && !dbg;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_DEBUG_NO_ALERT: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in) clk_en_in && dbg |=> !bus_alert_pin_out)
        else $error("Alert raised in debug");
    AST_DEBUG_NO_PULL: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in) clk_en_in && dbg |=> !fault_bus_pin_oe_out)
        else $error("Fault bus pulled in debug");
    AST_FAULT_SHUTDOWN: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && in_fault && !dbg |=> shutdown_req_out)
        else $error("Input fault without shutdown");
    AST_MARGIN_LOW: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && men && mlo |=> margin_low_out == $past(margin_allow_in))
        else $error("Margin low not applied");
    AST_MARGIN_OFF: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && !men |=> margin_low_out == '0 && margin_high_out == '0)
        else $error("Margin without enable");
    AST_BUS_NEEDS_EN: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && !(|r_bus) |=> !fault_bus_pin_oe_out)
        else $error("Bus driven without fault enable");
    AST_BUS_DRIVE: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && rail_fault_in && (|r_bus) && !dbg |=> bus_drive_q)
        else $error("Fault not driven on bus");
    AST_DEP_ON: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && !dbg && seq_req_in.on_seek[0] && !on_ok[0]
        |=> !rail_on_go_out[0])
        else $error("Rail on with dependency unmet");
    AST_DEBUG_NO_LOG: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && dbg |=> !fault_log_out && !shutdown_req_out)
        else $error("Fault logged in debug");
    AST_DEBUG_WAITS: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && dbg |=> (rail_on_go_out &
            ~$past(tmo_expired_in | tmo_zero_in)) == '0)
        else $error("Rail released in debug before timeout");
    AST_DEBUG_LOGIC_OUT: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && dbg |=> logic_output_pin_out == '0)
        else $error("Logic outputs held in debug");
    AST_COMM_STICKY: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && comm_fault_in |=> comm_fault_status_register_out)
        else $error("Communication fault lost");
    AST_BUS_RELEASE: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && !rail_fault_in && fault_clear_in |=> !bus_drive_q)
        else $error("Fault bus held after clear");
    AST_BUS_NO_ECHO: assert property (@(posedge clk_sys_in)
        disable iff (sys_rst_in)
        clk_en_in && bus_drive_q |=> !bus_fault_seen_out)
        else $error("Own drive reported as peer fault");

endmodule

// ### gpi_fault_peer.sv
// Purpose: Peer sequencer sharing the wired-low fault bus
// Assumes: Bus has a pull-up, so a released bus reads high
// Notes:   Peer pulls only when the bench commands it
module gpi_fault_peer (
    // Clock
    input  wire logic clk_sys_in,
    // Control and bus
    input  wire logic pull_req_in,
    input  wire logic dut_oe_in,
    input  wire logic dut_out_in,
    output logic      peer_oe_out,
    output logic      bus_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Peer acts just after an edge, like a real sequencer
    always_ff @(posedge clk_sys_in) begin
        peer_oe_out <= pull_req_in;
    end
    // Wired-low bus: any driver low wins over the pull-up
    assign bus_level_out = !((dut_oe_in && !dut_out_in) || peer_oe_out);
endmodule

// ### gpi_pkg.sv
// Purpose: Shared constants and carriers for the sequencer input pin block
// Assumes: One system clock, synchronous active-high reset
// Notes:   Role codes and counts used by the input block and its bench
package gpi_pkg;

    // ************************************************************
    // Counts
    // ************************************************************
    localparam int NUM_PINS       = 84;
    localparam int MAX_INPUTS     = 32;
    localparam int SEL_INPUTS     = 3;
    localparam int NUM_RAILS      = 32;
    localparam int TMO_W          = 16;
    localparam int ECHO_DEPTH     = 3;
    localparam logic [4:0] IDX_RST = 5'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       fault_en;
        logic       clr_latch;
        logic       margin_en;
        logic       margin_low;
        logic       debug;
        logic       fault_bus;
    } role_t;

    typedef struct packed {
        logic [NUM_RAILS-1:0] on_seek;
        logic [NUM_RAILS-1:0] off_seek;
    } seq_req_t;

endpackage

// ### gpi_sync.sv
// Purpose: Two-stage synchroniser with polarity, one bit per input
// Assumes: Inputs arrive from outside the clock domain
// Notes:   First stage feeds only the second stage
module gpi_sync #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    // Data
    input  wire logic [WIDTH-1:0] raw_in,
    input  wire logic [WIDTH-1:0] active_low_in,
    output logic      [WIDTH-1:0] asserted_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (clk_en_in) begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // Polarity decides what counts as asserted
    assign asserted_out = sync_q ^ active_low_in;

endmodule

// ### tb_sequencer_input_pin_functions.sv
// Purpose: Self-checking bench for the sequencer input pin block
// Assumes: Outputs settle three edges after a pin change
// Notes:   Eight inputs and four rails keep the run short
module tb_sequencer_input_pin_functions;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 8;
    localparam int R = 4;
    localparam logic [5:0] FLT = 6'h20;
    localparam logic [5:0] CLR = 6'h10;
    localparam logic [5:0] MEN = 6'h08;
    localparam logic [5:0] MLO = 6'h04;
    localparam logic [5:0] DBG = 6'h02;
    localparam logic [5:0] BUS = 6'h01;
    logic clk = 1'b0, rst = 1'b1, cen = 1'b1, rflt = 1'b0, fclr = 1'b0;
    logic cfl = 1'b0, ppull = 1'b0;
    logic [N-1:0] pin = '0, pol = '0, defd = '0;
    gpi_pkg::role_t [N-1:0] role = '0;
    logic [R-1:0][N-1:0] ond = '0, offd = '0;
    gpi_pkg::seq_req_t seq = '0;
    logic [R-1:0] texp = '0, tzero = '0, depok = '0, mall = '0;
    logic [15:0] lgf = '0;
    wire logic bus, oe, bout, poe, inf, shut, flog, alrt, lclr, dbg;
    wire logic cml, bseen, rerr;
    wire logic [N-1:0] asrt;
    wire logic [R-1:0] ongo, offgo, mlo, mhi;
    wire logic [2:0] sel;
    wire logic [15:0] lpo;
    int bad_count = 0;
    int total_checks = 0;
    always #5 clk = ~clk;

    gpi_fault_peer i_peer (.clk_sys_in(clk), .pull_req_in(ppull),
        .dut_oe_in(oe), .dut_out_in(bout), .peer_oe_out(poe),
        .bus_level_out(bus));
    gpi_core #(.NUM_IN(N), .RAILS(R)) i_dut (
        .clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
        .pin_level_in(pin), .active_low_in(pol), .defined_in(defd),
        .role_in(role), .on_dep_in(ond), .off_dep_in(offd),
        .seq_req_in(seq), .tmo_expired_in(texp), .tmo_zero_in(tzero),
        .rail_dep_ok_in(depok), .margin_allow_in(mall),
        .rail_fault_in(rflt), .fault_clear_in(fclr), .comm_fault_in(cfl),
        .logic_out_fault_in(lgf), .fault_bus_pin_in(bus),
        .fault_bus_pin_out(bout), .fault_bus_pin_oe_out(oe),
        .asserted_out(asrt), .rail_on_go_out(ongo),
        .rail_off_go_out(offgo), .state_sel_out(sel),
        .input_fault_out(inf), .shutdown_req_out(shut),
        .fault_log_out(flog), .bus_alert_pin_out(alrt),
        .latch_clear_out(lclr), .margin_low_out(mlo),
        .margin_high_out(mhi), .debug_mode_out(dbg),
        .comm_fault_status_register_out(cml),
        .logic_output_pin_out(lpo), .bus_fault_seen_out(bseen),
        .role_error_out(rerr));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Three edges of latency plus one of margin
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_oe(logic v);
        int i;
        for (i = 0; i < 10 && oe !== v; i++) @(negedge clk);
        if (oe !== v) begin
            chk("oe_timeout", {31'h0, oe}, {31'h0, v});
            final_report();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_polarity();
        defd = 8'hfe; pol = 8'h0f; pin = 8'h35; settle();
        chk("asserted", asrt, 8'h3a);
    endtask
    task automatic t_freeze();
        defd = 8'hff; pol = '0; pin = 8'h0f; settle();
        cen = 1'b0; pin = 8'hf0; settle();
        chk("frozen", asrt, 8'h0f);
        cen = 1'b1; settle();
        chk("thawed", asrt, 8'hf0);
        pin = '0;
    endtask
    task automatic t_select();
        defd = 8'hb4; pol = '0; pin = 8'h30; settle();
        chk("sel_a", sel, 3'h6);
        pin = 8'h04; settle();
        chk("sel_b", sel, 3'h1);
    endtask
    task automatic t_depend();
        defd = 8'hff; pin = '0; depok = 4'hf; ond[0] = 8'h02;
        offd[1] = 8'h02; seq.on_seek = 32'h1; seq.off_seek = 32'h2;
        settle();
        chk("dep_off", {ongo[0], offgo[1]}, 2'h1);
        pin = 8'h02; settle();
        chk("dep_on", {ongo[0], offgo[1]}, 2'h2);
        seq = '0; ond = '0; offd = '0;
    endtask
    task automatic t_fault();
        role[3] = FLT; pin = 8'h08; lgf = 16'ha5c3; settle();
        chk("lpo", lpo, 16'ha5c3);
        pin = 8'h00; settle();
        chk("flt", {inf, shut, flog, alrt}, 4'hf);
        role[6] = DBG; pin = 8'h40; settle();
        chk("dbg_flt", {dbg, inf, shut, flog, alrt}, 5'h18);
        chk("dbg_lpo", lpo, 16'h0);
        cfl = 1'b1; @(negedge clk); cfl = 1'b0; settle();
        chk("cml", cml, 1'b1);
        role[2] = CLR; pin = 8'h44; settle();
        chk("clr", {lclr, cml}, 2'h2);
        role = '0; pin = '0;
    endtask
    task automatic t_debug_seq();
        role[6] = DBG; pin = 8'h40; depok = '0; ond = {4{8'h01}};
        seq.on_seek = 32'h7; texp = 4'h1; tzero = 4'h2; settle();
        chk("dbg_go", ongo, 4'h3);
        pin = '0; settle();
        chk("nodbg_go", ongo, 4'h0);
        role = '0; seq = '0; ond = '0; texp = '0; tzero = '0;
    endtask
    task automatic t_margin();
        role[4] = MEN; role[5] = MLO; mall = 4'h3; pin = 8'h30; settle();
        chk("m_low", {mlo, mhi}, 8'h30);
        pin = 8'h10; settle();
        chk("m_high", {mlo, mhi}, 8'h03);
        role[7] = MEN; pin = 8'h90; settle();
        chk("m_dup", {rerr, mlo, mhi}, 9'h100);
        role = '0; pin = '0;
    endtask
    task automatic t_bus();
        role[1] = BUS; pin = 8'h02; rflt = 1'b1; settle();
        chk("bus_noen", oe, 1'b0);
        role[1] = FLT | BUS; wait_oe(1'b1);
        chk("bus_low", {bus, bseen, bout}, 3'h0);
        rflt = 1'b0; fclr = 1'b1; @(negedge clk); fclr = 1'b0;
        wait_oe(1'b0);
        chk("bus_rel", {bus, bseen}, 2'h2);
        ppull = 1'b1; settle();
        chk("bus_seen", {bus, bseen}, 2'h1);
        ppull = 1'b0; role[6] = DBG; pin = 8'h42; settle();
        rflt = 1'b1; settle();
        chk("bus_dbg", oe, 1'b0);
        rflt = 1'b0; role = '0; pin = '0;
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("rst", {asrt, oe, shut}, '0);
        t_polarity();
        t_freeze();
        t_select();
        t_depend();
        t_fault();
        t_debug_seq();
        t_margin();
        t_bus();
        final_report();
    end
endmodule
